// File: tb_zcd_core.sv
// Self-checking bench for zcd_core with the AC source model
// Assumes the checker and the source model are compiled first
`timescale 1ns/10ps
module tb_zcd_core;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        strap = 1'b1;
    logic        sleep = 1'b0;
    logic        above = 1'b0;
    logic        route_oe = 1'b0;
    logic        comp;
    logic        act;
    logic        pin_out;
    logic        pin_oe;
    logic        obs;
    logic        irq;
    logic [31:0] q;
    logic        bad;
    int          errors = 0;
    int          comparisons = 0;
    always #20 clk = ~clk;
    zcd_ac_source src_u (.above_ref(above), .sink_active(comp));
    zcd_core dut_u (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .WB_ERR_O(err), .DETECTOR_DEFAULT_OFF(strap), .SLEEP(sleep), .COMP_SINK_ACTIVE(comp),
        .PIN_ROUTE_OUT(1'b1), .PIN_ROUTE_OE(route_oe), .DETECTOR_ACTIVE(act), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .CROSSING_OBSERVE_PIN(obs), .IRQ(irq));
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
            errors++;
        if (g !== e)
            $display("[ERR] %0t got %h want %h", $time, g, e);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        bad = err;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1 && err !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t bus request not answered", $time);
            tally_and_finish();
        end
    endtask
    // Waits for irq to rise, or for the whole span when none is expected
    task automatic wirq(input logic e);
        repeat (12)
        begin
            @(posedge clk);
            if (e && irq === 1'b1)
                break;
        end
        chk(irq, e);
        if (irq !== e)
            tally_and_finish();
    endtask
    task automatic t_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(act, !s);
        chk({act, pin_oe, pin_out}, {29'h0, !s, !s, s});
        wb(1'b0, 4'h0, 8'h0);
        chk(q & 32'hffffffdf, {24'h0, !s, 7'h0});
        $display("reset test done");
    endtask
    task automatic t_regs();
        wb(1'b1, 4'h0, 8'h80);
        chk({act, pin_oe, pin_out}, 32'h6);
        wb(1'b1, 4'h0, 8'hff);
        wb(1'b0, 4'h0, 8'h0);
        chk(q, 32'hb3);
        wb(1'b1, 4'h0, 8'h80);
        chk(irq, 1'b0);
        wb(1'b1, 4'h8, 8'h01);
        chk(irq, 1'b1);
        wb(1'b0, 4'h4, 8'h0);
        chk({q[30:0], irq}, 32'h2);
        wb(1'b0, 4'h0, 8'h0);
        chk(q, 32'h80);
        wb(1'b1, 4'hc, 8'hff);
        chk(bad, 1'b1);
        $display("register test done");
    endtask
    task automatic t_edges();
        sleep <= 1'b1;
        wb(1'b1, 4'h0, 8'h82);
        above <= 1'b1;
        wirq(1'b1);
        chk(obs, 1'b1);
        wb(1'b0, 4'h4, 8'h0);
        above <= 1'b0;
        wirq(1'b0);
        wb(1'b1, 4'h0, 8'h81);
        above <= 1'b1;
        wirq(1'b0);
        above <= 1'b0;
        wirq(1'b1);
        // Clear the fall event first so only the invert change can set the flag
        wb(1'b0, 4'h4, 8'h0);
        chk(irq, 1'b0);
        wb(1'b1, 4'h0, 8'h91);
        wb(1'b0, 4'h4, 8'h0);
        chk(q, 32'h1);
        above <= 1'b1;
        wirq(1'b1);
        chk(obs, 1'b0);
        wb(1'b0, 4'h4, 8'h0);
        // Source flips 57 ns after the edge; the synchronised edge then meets the read
        wb(1'b1, 4'h0, 8'h93);
        above <= 1'b0;
        repeat (2) @(posedge clk);
        wb(1'b0, 4'h4, 8'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h4, 8'h0);
        chk(q, 32'h1);
        $display("edge test done");
    endtask
    initial
    begin
        t_reset(1'b1);
        t_regs();
        t_edges();
        t_reset(1'b0);
        tally_and_finish();
    end
endmodule // tb_zcd_core

// File: zcd_ac_source.sv
// AC source behind the series resistor, as the comparator sees it
// Assumes the bench moves the applied voltage across the reference
`timescale 1ns/10ps
module zcd_ac_source
#(
    parameter int SETTLE_NS = 57
)
(
    input  logic above_ref,
    output logic sink_active
);
    // Sinks while above reference; the delay keeps flips off the clock grid
    initial sink_active = 1'b0;
    always @(above_ref)
        sink_active <= #(SETTLE_NS) above_ref;
endmodule // zcd_ac_source

// File: zcd_core.v
// Zero-cross detector control and status logic with a Wishbone slave
// Assumes the analog source/sink and comparator sit outside; comparator is async
`timescale 1ns/10ps
`include "zcd_defines.vh"

module zcd_core
(
    CORE_CLK,
    RST,
    WB_CYC_I,
    WB_STB_I,
    WB_WE_I,
    WB_ADR_I,
    WB_SEL_I,
    WB_DAT_I,
    WB_DAT_O,
    WB_ACK_O,
    WB_ERR_O,
    DETECTOR_DEFAULT_OFF,
    SLEEP,
    COMP_SINK_ACTIVE,
    PIN_ROUTE_OUT,
    PIN_ROUTE_OE,
    DETECTOR_ACTIVE,
    PIN_OUT,
    PIN_OE,
    CROSSING_OBSERVE_PIN,
    IRQ
);

    input  wire        CORE_CLK;
    input  wire        RST;
    input  wire        WB_CYC_I;
    input  wire        WB_STB_I;
    input  wire        WB_WE_I;
    input  wire [3:0]  WB_ADR_I;
    input  wire [3:0]  WB_SEL_I;
    input  wire [31:0] WB_DAT_I;
    output reg  [31:0] WB_DAT_O;
    output reg         WB_ACK_O;
    output reg         WB_ERR_O;
    input  wire        DETECTOR_DEFAULT_OFF;
    input  wire        SLEEP;
    input  wire        COMP_SINK_ACTIVE;
    input  wire        PIN_ROUTE_OUT;
    input  wire        PIN_ROUTE_OE;
    output wire        DETECTOR_ACTIVE;
    output wire        PIN_OUT;
    output wire        PIN_OE;
    output reg         CROSSING_OBSERVE_PIN;
    output wire        IRQ;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg        enable_ff;
    reg        output_invert_ff;
    reg        rise_irq_enable_ff;
    reg        fall_irq_enable_ff;
    reg        strap_taken_ff;
    reg        crossing_irq_flag_ff;
    reg        irq_mask_ff;
    reg        logic_prev_ff;
    reg        prev_valid_ff;

    wire       sink_sync;
    wire       crossing_logic_output;
    wire       bus_req;
    wire       wr_req;
    wire       rd_req;
    wire       hit_ctrl;
    wire       hit_stat;
    wire       hit_mask;
    wire       addr_ok;
    wire       rise_evt;
    wire       fall_evt;
    wire       invert_evt;
    wire       cross_set;
    wire       cross_clr;
    wire [7:0] ctrl_rd;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function addr_is;
        input [3:0] adr;
        input [3:0] ofs;
        begin
            addr_is = (adr[3:2] == ofs[3:2]);
        end
    endfunction

    // ----------------------------------------------------------------
    // Comparator path
    // ----------------------------------------------------------------
    zcd_sync u_sync
    (
        .clk  (CORE_CLK),
        .rst  (RST),
        .din  (COMP_SINK_ACTIVE),
        .dout (sink_sync)
    );

    // Sleep has no effect here: nothing gates on it so detection runs on
    assign crossing_logic_output = sink_sync ^ output_invert_ff;

    // ----------------------------------------------------------------
    // Pin takeover
    // ----------------------------------------------------------------
    assign DETECTOR_ACTIVE = enable_ff;
    assign PIN_OUT = enable_ff ? 1'b0 : PIN_ROUTE_OUT;
    assign PIN_OE  = enable_ff ? 1'b1 : PIN_ROUTE_OE;

    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            CROSSING_OBSERVE_PIN <= 1'b0;
        else
            CROSSING_OBSERVE_PIN <= enable_ff & crossing_logic_output;
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
    assign hit_ctrl = addr_is(WB_ADR_I, `ZCD_OFS_CONTROL);
    assign hit_stat = addr_is(WB_ADR_I, `ZCD_OFS_STATUS);
    assign hit_mask = addr_is(WB_ADR_I, `ZCD_OFS_MASK);
    assign addr_ok  = (hit_ctrl | hit_stat | hit_mask) & (WB_ADR_I[1:0] == 2'h0);
    assign wr_req   = bus_req & addr_ok & WB_WE_I;
    assign rd_req   = bus_req & addr_ok & ~WB_WE_I;

    assign ctrl_rd = {enable_ff, 1'b0, crossing_logic_output, output_invert_ff,
                      2'b00, rise_irq_enable_ff, fall_irq_enable_ff};

    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            WB_ACK_O <= 1'b0;
            WB_ERR_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end
        else
        begin
            WB_ACK_O <= bus_req & addr_ok;
            WB_ERR_O <= bus_req & ~addr_ok;
            if (rd_req)
            begin
                if (hit_ctrl)
                    WB_DAT_O <= {24'h000000, ctrl_rd};
                else if (hit_stat)
                    WB_DAT_O <= {31'h0, crossing_irq_flag_ff};
                else
                    WB_DAT_O <= {31'h0, irq_mask_ff};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    wire ctrl_wr = wr_req & hit_ctrl & WB_SEL_I[0];

    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            enable_ff          <= 1'b0;
            output_invert_ff   <= 1'b0;
            rise_irq_enable_ff <= 1'b0;
            fall_irq_enable_ff <= 1'b0;
            strap_taken_ff     <= 1'b0;
            irq_mask_ff        <= `ZCD_MASK_RESET;
        end
        else
        begin
            // Strap caught on the first edge after release, not under reset
            if (!strap_taken_ff)
            begin
                strap_taken_ff <= 1'b1;
                enable_ff      <= ~DETECTOR_DEFAULT_OFF;
            end
            else if (ctrl_wr)
                enable_ff <= WB_DAT_I[`ZCD_BIT_ENABLE];
            if (ctrl_wr)
            begin
                output_invert_ff   <= WB_DAT_I[`ZCD_BIT_INVERT];
                rise_irq_enable_ff <= WB_DAT_I[`ZCD_BIT_RISE_EN];
                fall_irq_enable_ff <= WB_DAT_I[`ZCD_BIT_FALL_EN];
            end
            if (wr_req & hit_mask & WB_SEL_I[0])
                irq_mask_ff <= WB_DAT_I[`ZCD_BIT_CROSS];
        end
    end

    // ----------------------------------------------------------------
    // Edge detection and crossing flag
    // ----------------------------------------------------------------
    // First sample after reset only primes the history, avoiding a false edge
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            logic_prev_ff <= 1'b0;
            prev_valid_ff <= 1'b0;
        end
        else
        begin
            logic_prev_ff <= sink_sync;
            prev_valid_ff <= 1'b1;
        end
    end

    // Edges use the raw level so an invert toggle is not counted twice
    wire raw_rise = prev_valid_ff & sink_sync & ~logic_prev_ff;
    wire raw_fall = prev_valid_ff & ~sink_sync & logic_prev_ff;
    assign rise_evt = rise_irq_enable_ff &
                      (output_invert_ff ? raw_fall : raw_rise);
    assign fall_evt = fall_irq_enable_ff &
                      (output_invert_ff ? raw_rise : raw_fall);
    assign invert_evt = ctrl_wr &
                        (WB_DAT_I[`ZCD_BIT_INVERT] != output_invert_ff);
    assign cross_set = rise_evt | fall_evt | invert_evt;
    assign cross_clr = rd_req & hit_stat;

    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            crossing_irq_flag_ff <= 1'b0;
        else if (cross_set)
            crossing_irq_flag_ff <= 1'b1;
        else if (cross_clr)
            crossing_irq_flag_ff <= 1'b0;
    end

    assign IRQ = crossing_irq_flag_ff & irq_mask_ff;

endmodule // zcd_core

// File: zcd_core_assertions.sv
// Checker for zcd_core, bound to it at the foot of this file
// Assumes one clock, CORE_CLK, and the asynchronous active-high RST
`timescale 1ns/10ps
module zcd_core_assertions
(
    input logic        CORE_CLK,
    input logic        RST,
    input logic        WB_CYC_I,
    input logic        WB_STB_I,
    input logic        WB_WE_I,
    input logic [3:0]  WB_ADR_I,
    input logic [31:0] WB_DAT_O,
    input logic        WB_ACK_O,
    input logic        WB_ERR_O,
    input logic        DETECTOR_DEFAULT_OFF,
    input logic        COMP_SINK_ACTIVE,
    input logic        PIN_ROUTE_OUT,
    input logic        PIN_ROUTE_OE,
    input logic        DETECTOR_ACTIVE,
    input logic        PIN_OUT,
    input logic        PIN_OE,
    input logic        CROSSING_OBSERVE_PIN
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    wire  req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    logic rd_ff;
    logic rdc_ff;
    always @(posedge CORE_CLK or posedge RST)
    begin
        rd_ff  <= RST ? 1'b0 : req && !WB_WE_I;
        rdc_ff <= RST ? 1'b0 : req && !WB_WE_I && WB_ADR_I == 4'h0;
    end
    a_ack_answer: assert property (req |=> WB_ACK_O != WB_ERR_O)
        else $error("request not answered exactly once");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_err_unmapped: assert property (req |=> WB_ERR_O == !($past(WB_ADR_I) inside {4'h0, 4'h4, 4'h8}))
        else $error("error answer does not match address");
    a_pin_takeover: assert property (PIN_OE == (DETECTOR_ACTIVE | PIN_ROUTE_OE) &&
        PIN_OUT == (!DETECTOR_ACTIVE & PIN_ROUTE_OUT)) else $error("pin ownership wrong");
    a_observe_gated: assert property (!$past(DETECTOR_ACTIVE) && !DETECTOR_ACTIVE |->
        !CROSSING_OBSERVE_PIN) else $error("observe pin high while disabled");
    a_default_strap: assert property ($past(RST, 2) && !$past(RST) |->
        DETECTOR_ACTIVE == !$past(DETECTOR_DEFAULT_OFF)) else $error("enable not from strap");
    a_reserved_zero: assert property (WB_ACK_O && rd_ff |-> WB_DAT_O[31:8] == 24'h0 &&
        !WB_DAT_O[6] && WB_DAT_O[3:2] == 2'h0) else $error("reserved read bits set");
    // Comparator equal to its value four edges back, taken as the synchroniser having settled
    a_level_encode: assert property (WB_ACK_O && rdc_ff &&
        $past(COMP_SINK_ACTIVE, 4) == COMP_SINK_ACTIVE |->
        WB_DAT_O[5] == (WB_DAT_O[4] ^ COMP_SINK_ACTIVE)) else $error("level bit wrong");
endmodule // zcd_core_assertions

bind zcd_core zcd_core_assertions u_chk
(
    .CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .DETECTOR_DEFAULT_OFF(DETECTOR_DEFAULT_OFF),
    .COMP_SINK_ACTIVE(COMP_SINK_ACTIVE), .PIN_ROUTE_OUT(PIN_ROUTE_OUT),
    .PIN_ROUTE_OE(PIN_ROUTE_OE), .DETECTOR_ACTIVE(DETECTOR_ACTIVE), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .CROSSING_OBSERVE_PIN(CROSSING_OBSERVE_PIN)
);

// File: zcd_defines.vh
// Register offsets, field positions, reset values and timing for the zero-cross logic
// Assumes a 32-bit classic Wishbone slave with word-aligned registers
`ifndef ZCD_DEFINES_VH
`define ZCD_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ZCD_OFS_CONTROL   4'h0
`define ZCD_OFS_STATUS    4'h4
`define ZCD_OFS_MASK      4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ZCD_BIT_ENABLE    7
`define ZCD_BIT_LEVEL     5
`define ZCD_BIT_INVERT    4
`define ZCD_BIT_RISE_EN   1
`define ZCD_BIT_FALL_EN   0
`define ZCD_CTRL_WMASK    8'h93

// ----------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------
`define ZCD_BIT_CROSS     0
`define ZCD_STAT_WIDTH    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ZCD_CTRL_RESET    8'h00
`define ZCD_MASK_RESET    1'h0

// ----------------------------------------------------------------
// Timing: clock period and synchroniser depth
// ----------------------------------------------------------------
`define ZCD_CLK_PERIOD_NS 40
`define ZCD_SYNC_STAGES   2

`endif

// File: zcd_sync.v
// Two-flop level synchroniser for the asynchronous comparator result
// Assumes one clock and an asynchronous active-high reset
`timescale 1ns/10ps
`include "zcd_defines.vh"

module zcd_sync
(
    input  wire clk,
    input  wire rst,
    input  wire din,
    output wire dout
);

    reg meta_ff;
    reg sync_ff;

    // First flop is read only by the second
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule // zcd_sync
